// ### rtl/power_mode_irq_ctrl.sv
/*
 * power mode and interrupt control: sleep-instruction mode selection,
 * clock and wait selection, and interrupt enable/request flags.
 * assumes i_sleep_exec and the event inputs are one-cycle pulses
 * synchronous to i_core_clk; registers are reached over ahb-lite.
 */
// Implementation choice: the AHB-Lite interface to the registers.
// How it works
// R01: subactive sleep, standby clear: enter subsleep (code: only with direct clear; with direct set it stays subactive)
// R02: no direct: active sleep gives standby/watch/sleep
// R03: no direct: subactive sleep gives watch/subsleep
// R04: direct: high-speed to medium-speed active
// R05: direct: medium-speed to high-speed active
// R06: direct: either active mode to subactive
// R07: direct: subactive to high or medium active
// R08: medium speed bit picks active speed
// R09: subclock divider field picks watch divide
// R10: noise bit picks osc/16 or osc/4
// R11: external enables gate pin requests
// R12: software writes zero to reserved enables
// R13: flags clear on written zero only
// R14: selected pin edge sets external flag
// R15: timer wrap sets timer flag
// R16: serial completion sets serial flag
// R17: low speed bit picks system or subclock
// R18: wait field picks settling wait length
// R19: timer, serial, wake enables gate requests
`default_nettype none
module power_mode_irq_ctrl (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic i_hready,
    input wire logic [31:0] i_hwdata,
    input wire logic i_sleep_exec,
    input wire logic i_timer_prescaler_bit3,
    input wire logic [4:0] i_ext_irq_edge,
    input wire logic i_wake_pin_event,
    input wire logic i_timer_a_wrap,
    input wire logic i_serial1_done,
    input wire logic i_wakeup,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [6:0] o_power_mode,
    output logic o_cpu_on_subclock,
    output logic [1:0] o_subclock_div_sel,
    output logic [3:0] o_noise_div,
    output logic o_settling,
    output logic [7:0] o_irq_pending,
    output logic o_wake_irq,
    output logic o_irq
);
    reg_access_if rb ();

    ahb_reg_slave u_slave (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst),
        .i_hsel(i_hsel),
        .i_haddr(i_haddr),
        .i_htrans(i_htrans),
        .i_hwrite(i_hwrite),
        .i_hready(i_hready),
        .i_hwdata(i_hwdata),
        .o_hrdata(o_hrdata),
        .bus(rb)
    );

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] cfg1, cfg2, irq_en, irq_req;
    logic [7:0] next_cfg1, next_cfg2, next_irq_en, next_irq_req;
    logic [2:0] evt_stat, evt_mask, next_evt_stat, next_evt_mask;
    logic [7:0] set_req;
    logic wr_req;

    always_comb begin
        set_req = 8'h00;
        set_req[power_irq_pkg::N_EXT-1:0] = i_ext_irq_edge;  // [R14]
        set_req[power_irq_pkg::B_TIMER_A] = i_timer_a_wrap;  // [R15]
        set_req[power_irq_pkg::B_SERIAL1] = i_serial1_done;  // [R16]
        wr_req = rb.wr && rb.idx == power_irq_pkg::IDX_IRQ_REQ1;
        next_cfg1 = cfg1;
        next_cfg2 = cfg2;
        next_irq_en = irq_en;
        next_evt_mask = evt_mask;
        if (rb.wr && rb.idx == power_irq_pkg::IDX_SLEEP_CFG1) begin
            next_cfg1 = (rb.wdata & power_irq_pkg::CFG1_WMASK)
                | (power_irq_pkg::RST_SLEEP_CFG1 & ~power_irq_pkg::CFG1_WMASK);
        end
        if (rb.wr && rb.idx == power_irq_pkg::IDX_SLEEP_CFG2) begin
            next_cfg2 = (rb.wdata & power_irq_pkg::CFG2_WMASK)
                | (power_irq_pkg::RST_SLEEP_CFG2 & ~power_irq_pkg::CFG2_WMASK);
        end
        if (rb.wr && rb.idx == power_irq_pkg::IDX_IRQ_EN1) begin
            next_irq_en = rb.wdata;
        end
        if (rb.wr && rb.idx == power_irq_pkg::IDX_IRQ_MASK) begin
            next_evt_mask = rb.wdata[2:0];
        end
        // a written 1 keeps the flag; a written 0 clears; a new event wins
        next_irq_req = (wr_req ? (irq_req & rb.wdata) : irq_req) | set_req;  // [R13]
        next_irq_req = next_irq_req | power_irq_pkg::REQ1_FIXED_ONE;
    end

    ////////////////////////////////////////////////////////////////////////
    power_irq_pkg::power_mode_t mode, next_mode;
    logic [16:0] wait_cnt, next_wait_cnt, wait_len;
    logic mode_chg, wait_done;
    logic stby_sel, low_spd, med_spd, direct_en, ta3;

    always_comb begin
        stby_sel = cfg1[power_irq_pkg::B_STANDBY_SELECT];
        low_spd = cfg1[power_irq_pkg::B_LOW_SPEED];
        med_spd = cfg2[power_irq_pkg::B_MEDIUM_SPEED];
        direct_en = cfg2[power_irq_pkg::B_DIRECT_XFER];
        ta3 = i_timer_prescaler_bit3;
        unique case (cfg1[power_irq_pkg::B_WAIT_HI:power_irq_pkg::B_WAIT_LO])  // [R18]
            3'h0: wait_len = 17'(power_irq_pkg::WAIT_STATES_0 - 1);
            3'h1: wait_len = 17'(power_irq_pkg::WAIT_STATES_1 - 1);
            3'h2: wait_len = 17'(power_irq_pkg::WAIT_STATES_2 - 1);
            3'h3: wait_len = 17'(power_irq_pkg::WAIT_STATES_3 - 1);
            default: wait_len = 17'(power_irq_pkg::WAIT_STATES_4 - 1);
        endcase
        next_mode = mode;
        next_wait_cnt = wait_cnt;
        wait_done = 1'b0;
        unique case (mode)
            power_irq_pkg::M_HIGH_ACTIVE, power_irq_pkg::M_MED_ACTIVE: begin
                if (i_sleep_exec) begin
                    if (direct_en && stby_sel && ta3 && low_spd) begin
                        next_mode = power_irq_pkg::M_SUBACTIVE;  // [R06]
                    end else if (direct_en && !stby_sel && med_spd && !low_spd &&
                                 mode == power_irq_pkg::M_HIGH_ACTIVE) begin
                        next_mode = power_irq_pkg::M_MED_ACTIVE;  // [R04]
                    end else if (direct_en && !stby_sel && !med_spd && !low_spd &&
                                 mode == power_irq_pkg::M_MED_ACTIVE) begin
                        next_mode = power_irq_pkg::M_HIGH_ACTIVE;  // [R05]
                    end else if (!direct_en) begin
                        // [R02]
                        if (!stby_sel) begin
                            next_mode = power_irq_pkg::M_SLEEP;
                        end else if (low_spd) begin
                            next_mode = power_irq_pkg::M_WATCH;
                        end else begin
                            next_mode = power_irq_pkg::M_STANDBY;
                        end
                    end
                end
            end
            power_irq_pkg::M_SUBACTIVE: begin
                if (i_sleep_exec) begin
                    if (direct_en && stby_sel && ta3 && !low_spd) begin
                        // [R07] [R08]
                        next_mode = med_spd ? power_irq_pkg::M_MED_ACTIVE
                                            : power_irq_pkg::M_HIGH_ACTIVE;
                    end else if (!direct_en) begin
                        // [R01] [R03]
                        next_mode = stby_sel ? power_irq_pkg::M_WATCH
                                         : power_irq_pkg::M_SUBSLEEP;
                    end
                end
            end
            power_irq_pkg::M_SLEEP: begin
                if (i_wakeup) begin
                    next_mode = med_spd ? power_irq_pkg::M_MED_ACTIVE
                                        : power_irq_pkg::M_HIGH_ACTIVE;  // [R08]
                end
            end
            power_irq_pkg::M_SUBSLEEP: begin
                if (i_wakeup) begin
                    next_mode = power_irq_pkg::M_SUBACTIVE;
                end
            end
            power_irq_pkg::M_STANDBY, power_irq_pkg::M_WATCH: begin
                if (wait_cnt != 17'h0_0000) begin
                    next_wait_cnt = wait_cnt - 17'h0_0001;
                    wait_done = (wait_cnt == 17'h0_0001);
                    if (wait_done) begin
                        next_mode = low_spd ? power_irq_pkg::M_SUBACTIVE
                                  : (med_spd ? power_irq_pkg::M_MED_ACTIVE
                                          : power_irq_pkg::M_HIGH_ACTIVE);
                    end
                end else if (i_wakeup) begin
                    next_wait_cnt = wait_len;  // [R18]
                end
            end
            default: next_mode = power_irq_pkg::M_HIGH_ACTIVE;
        endcase
        mode_chg = (next_mode != mode);
        next_evt_stat = evt_stat;
        if (rb.wr && rb.idx == power_irq_pkg::IDX_IRQ_STAT) begin
            next_evt_stat = evt_stat & ~rb.wdata[2:0];
        end
        next_evt_stat[power_irq_pkg::E_MODE_CHANGE] |= mode_chg;
        next_evt_stat[power_irq_pkg::E_WAIT_DONE] |= wait_done;
        next_evt_stat[power_irq_pkg::E_IRQ_REQUEST] |= |(set_req & irq_en);
    end

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] rdata;
    logic [7:0] pend;

    always_comb begin
        // [R11] [R19]
        pend = irq_req & irq_en & ~power_irq_pkg::REQ1_FIXED_ONE;
        unique case (rb.idx)
            power_irq_pkg::IDX_SLEEP_CFG1: rdata = cfg1;
            power_irq_pkg::IDX_SLEEP_CFG2: rdata = cfg2;
            power_irq_pkg::IDX_IRQ_EN1: rdata = irq_en;
            power_irq_pkg::IDX_IRQ_REQ1: rdata = irq_req;
            power_irq_pkg::IDX_IRQ_STAT: rdata = {5'h00, evt_stat};
            power_irq_pkg::IDX_IRQ_MASK: rdata = {5'h00, evt_mask};
            power_irq_pkg::IDX_MODE_STAT: rdata = {1'b0, mode};
            default: rdata = 8'h00;
        endcase
        rb.rdata = rdata;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            cfg1 <= power_irq_pkg::RST_SLEEP_CFG1;
            cfg2 <= power_irq_pkg::RST_SLEEP_CFG2;
            irq_en <= power_irq_pkg::RST_IRQ_EN1;
            irq_req <= power_irq_pkg::RST_IRQ_REQ1;
            evt_stat <= 3'h0;
            evt_mask <= 3'h0;
            mode <= power_irq_pkg::M_HIGH_ACTIVE;
            wait_cnt <= 17'h0_0000;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
            o_power_mode <= power_irq_pkg::M_HIGH_ACTIVE;
            o_cpu_on_subclock <= 1'b0;
            o_subclock_div_sel <= power_irq_pkg::SUBDIV_8;
            o_noise_div <= power_irq_pkg::NOISE_DIV_16;
            o_settling <= 1'b0;
            o_irq_pending <= 8'h00;
            o_wake_irq <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            cfg1 <= next_cfg1;
            cfg2 <= next_cfg2;
            irq_en <= next_irq_en;
            irq_req <= next_irq_req;
            evt_stat <= next_evt_stat;
            evt_mask <= next_evt_mask;
            mode <= next_mode;
            wait_cnt <= next_wait_cnt;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
            o_power_mode <= next_mode;
            o_cpu_on_subclock <= next_cfg1[power_irq_pkg::B_LOW_SPEED];  // [R17]
            o_subclock_div_sel <= next_cfg2[power_irq_pkg::B_SUBDIV_HI:power_irq_pkg::B_SUBDIV_LO];  // [R09]
            o_noise_div <= next_cfg2[power_irq_pkg::B_NOISE_SEL]
                ? power_irq_pkg::NOISE_DIV_4 : power_irq_pkg::NOISE_DIV_16;  // [R10]
            o_settling <= (next_wait_cnt != 17'h0_0000);
            o_irq_pending <= next_irq_req & next_irq_en
                & ~power_irq_pkg::REQ1_FIXED_ONE;
            o_wake_irq <= i_wake_pin_event && next_irq_en[power_irq_pkg::B_WAKE];  // [R19]
            o_irq <= |(next_evt_stat & next_evt_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_subsleep_entry: assert property (@(posedge i_core_clk) disable iff (i_srst) // [R01]
        mode == power_irq_pkg::M_SUBACTIVE && i_sleep_exec && !direct_en && !stby_sel
        |=> mode == power_irq_pkg::M_SUBSLEEP) else $error("no subsleep entry");
    a_sleep_entry: assert property (@(posedge i_core_clk) disable iff (i_srst) // [R02]
        mode == power_irq_pkg::M_HIGH_ACTIVE && i_sleep_exec && !direct_en && !stby_sel
        |=> mode == power_irq_pkg::M_SLEEP) else $error("no sleep entry");
    a_watch_entry: assert property (@(posedge i_core_clk) disable iff (i_srst) // [R03]
        mode == power_irq_pkg::M_SUBACTIVE && i_sleep_exec && !direct_en && stby_sel
        |=> mode == power_irq_pkg::M_WATCH) else $error("no watch entry");
    a_high_to_med: assert property (@(posedge i_core_clk) disable iff (i_srst) // [R04]
        mode == power_irq_pkg::M_HIGH_ACTIVE && i_sleep_exec && direct_en && !stby_sel
        && med_spd && !low_spd |=> o_power_mode == power_irq_pkg::M_MED_ACTIVE)
        else $error("no direct medium");
    a_med_to_high: assert property (@(posedge i_core_clk) disable iff (i_srst) // [R05]
        mode == power_irq_pkg::M_MED_ACTIVE && i_sleep_exec && direct_en && !stby_sel
        && !med_spd && !low_spd |=> mode == power_irq_pkg::M_HIGH_ACTIVE)
        else $error("no direct high");
    a_to_subactive: assert property (@(posedge i_core_clk) disable iff (i_srst) // [R06]
        (mode == power_irq_pkg::M_HIGH_ACTIVE || mode == power_irq_pkg::M_MED_ACTIVE)
        && i_sleep_exec && direct_en && stby_sel && ta3 && low_spd
        |=> mode == power_irq_pkg::M_SUBACTIVE) else $error("no direct sub");
    a_from_subactive: assert property (@(posedge i_core_clk) disable iff (i_srst) // [R07]
        mode == power_irq_pkg::M_SUBACTIVE && i_sleep_exec && direct_en && stby_sel && ta3
        && !low_spd |=> mode == ($past(med_spd) ? power_irq_pkg::M_MED_ACTIVE
        : power_irq_pkg::M_HIGH_ACTIVE)) else $error("bad sub exit");
    a_noise_rate: assert property (@(posedge i_core_clk) disable iff (i_srst) // [R10]
        o_noise_div == (cfg2[power_irq_pkg::B_NOISE_SEL]
        ? power_irq_pkg::NOISE_DIV_4 : power_irq_pkg::NOISE_DIV_16))
        else $error("noise rate wrong");
    a_flag_set: assert property (@(posedge i_core_clk) disable iff (i_srst) // [R15]
        i_timer_a_wrap |=> irq_req[power_irq_pkg::B_TIMER_A])
        else $error("timer flag lost");
    a_flag_hold: assert property (@(posedge i_core_clk) disable iff (i_srst) // [R13]
        !irq_req[power_irq_pkg::B_SERIAL1] && !i_serial1_done
        |=> !irq_req[power_irq_pkg::B_SERIAL1]) else $error("serial flag set");
    a_ext_gate: assert property (@(posedge i_core_clk) disable iff (i_srst) // [R11]
        o_irq_pending[0] == (irq_req[0] && irq_en[0]))
        else $error("ext gate wrong");
endmodule
`default_nettype wire

// ### rtl/power_irq_pkg.sv
/*
 * constants shared by the power mode and interrupt control block:
 * register offsets, field positions, reset values, mode codes, timing.
 * assumes a 32-bit ahb-lite slave port with word-per-register layout.
 */
`default_nettype none
package power_irq_pkg;
    // printed offsets are not multiples of four: these are indices
    localparam logic [7:0] IDX_SLEEP_CFG1 = 8'hf0;
    localparam logic [7:0] IDX_SLEEP_CFG2 = 8'hf1;
    localparam logic [7:0] IDX_IRQ_EN1 = 8'hf3;
    localparam logic [7:0] IDX_IRQ_REQ1 = 8'hf6;
    localparam logic [7:0] IDX_IRQ_STAT = 8'hf8;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hf9;
    localparam logic [7:0] IDX_MODE_STAT = 8'hfa;
    localparam logic [7:0] IDX_SLEEP_CMD = 8'hfb;

    localparam logic [7:0] RST_SLEEP_CFG1 = 8'h07;
    localparam logic [7:0] RST_SLEEP_CFG2 = 8'he0;
    localparam logic [7:0] RST_IRQ_EN1 = 8'h00;
    localparam logic [7:0] RST_IRQ_REQ1 = 8'h20;
    localparam logic [7:0] CFG1_WMASK = 8'hf8;
    localparam logic [7:0] CFG2_WMASK = 8'h1f;
    localparam logic [7:0] REQ1_FIXED_ONE = 8'h20;

    // sleep_mode_config_1 fields
    localparam int B_STANDBY_SELECT = 7;
    localparam int B_WAIT_HI = 6;
    localparam int B_WAIT_LO = 4;
    localparam int B_LOW_SPEED = 3;
    // sleep_mode_config_2 fields
    localparam int B_NOISE_SEL = 4;
    localparam int B_DIRECT_XFER = 3;
    localparam int B_MEDIUM_SPEED = 2;
    localparam int B_SUBDIV_HI = 1;
    localparam int B_SUBDIV_LO = 0;
    // interrupt enable / request fields
    localparam int B_TIMER_A = 7;
    localparam int B_SERIAL1 = 6;
    localparam int B_WAKE = 5;
    localparam int N_EXT = 5;

    // interrupt status bits: one per device event
    localparam int N_EVT = 3;
    localparam int E_MODE_CHANGE = 0;
    localparam int E_WAIT_DONE = 1;
    localparam int E_IRQ_REQUEST = 2;

    localparam int WAIT_STATES_0 = 8192;
    localparam int WAIT_STATES_1 = 16384;
    localparam int WAIT_STATES_2 = 32768;
    localparam int WAIT_STATES_3 = 65536;
    localparam int WAIT_STATES_4 = 131072;
    localparam int WAIT_W = 17;

    localparam logic [1:0] SUBDIV_8 = 2'h0;
    localparam logic [1:0] SUBDIV_4 = 2'h1;
    localparam logic [3:0] NOISE_DIV_16 = 4'hf;
    localparam logic [3:0] NOISE_DIV_4 = 4'h3;

    typedef enum logic [6:0] {
        M_HIGH_ACTIVE = 7'h01,
        M_MED_ACTIVE = 7'h02,
        M_SUBACTIVE = 7'h04,
        M_SLEEP = 7'h08,
        M_SUBSLEEP = 7'h10,
        M_STANDBY = 7'h20,
        M_WATCH = 7'h40
    } power_mode_t;
endpackage
`default_nettype wire

// ### rtl/reg_access_if.sv
/*
 * register-access bundle between the bus slave and the core.
 * assumes one clock; wr/rd strobes are one-cycle pulses.
 */
`default_nettype none
interface reg_access_if;
    logic wr;
    logic rd;
    logic [7:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport slave (output wr, output rd, output idx, output wdata, input rdata);
    modport core (input wr, input rd, input idx, input wdata, output rdata);
endinterface
`default_nettype wire

// ### rtl/ahb_reg_slave.sv
/*
 * ahb-lite slave turning word transfers into register strobes.
 * assumes single word transfers; always okay, one wait-free data phase.
 */
`default_nettype none
module ahb_reg_slave (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic i_hready,
    input wire logic [31:0] i_hwdata,
    output logic [31:0] o_hrdata,
    reg_access_if.slave bus
);
    logic pend_wr;
    logic [7:0] pend_idx;
    logic next_pend_wr;
    logic [7:0] next_pend_idx;
    logic take;

    always_comb begin
        take = i_hsel && i_htrans[1] && i_hready;
        next_pend_wr = take && i_hwrite;
        next_pend_idx = take ? i_haddr[9:2] : pend_idx;
        bus.rd = take && !i_hwrite;
        bus.idx = pend_wr ? pend_idx : i_haddr[9:2];
        bus.wr = pend_wr;
        bus.wdata = i_hwdata[7:0];
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            pend_wr <= 1'b0;
            pend_idx <= 8'h00;
            o_hrdata <= 32'h0000_0000;
        end else begin
            pend_wr <= next_pend_wr;
            pend_idx <= next_pend_idx;
            o_hrdata <= bus.rd ? {24'h00_0000, bus.rdata} : o_hrdata;
        end
    end
endmodule
`default_nettype wire

// ### dv/tb_top.sv
/*
 * self-checking bench for power_mode_irq_ctrl: sleep-mode selection,
 * clock fields, standby wait, request flags and the interrupt line.
 * assumes a zero-wait ahb-lite slave and one 50 MHz clock.
 */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_core_clk, i_srst, hsel, hwrite, pre3, rdy, settle, wake_irq, irq, subclk, resp;
    logic [1:0] htrans, sdiv;
    logic [3:0] ndiv;
    logic [6:0] mode;
    logic [7:0] pend;
    logic [9:0] ev;
    logic [31:0] haddr, hwdata, hrdata;
    int fail_count = 0;
    int comparisons = 0;

    power_mode_irq_ctrl dut (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hready(rdy), .i_hwdata(hwdata), .i_sleep_exec(ev[0]),
        .i_timer_prescaler_bit3(pre3), .i_ext_irq_edge(ev[9:5]), .i_wake_pin_event(ev[1]),
        .i_timer_a_wrap(ev[2]), .i_serial1_done(ev[3]), .i_wakeup(ev[4]),
        .o_hrdata(hrdata), .o_hreadyout(rdy), .o_hresp(resp), .o_power_mode(mode),
        .o_cpu_on_subclock(subclk), .o_subclock_div_sel(sdiv), .o_noise_div(ndiv),
        .o_settling(settle), .o_irq_pending(pend), .o_wake_irq(wake_irq), .o_irq(irq));

    initial begin
        i_core_clk = 1'b0;
        forever #10 i_core_clk = ~i_core_clk;
    end

////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic hang;
        fail_count++;
        wrap_up();
    endtask

    // hready is the slave's own hreadyout: no wait count is assumed
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        if (rdy !== 1'b1) hang();
    endtask

    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                        output logic [7:0] rd);
        @(posedge i_core_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {22'h0, idx, 2'h0};
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        wait_ready();
        rd = hrdata[7:0];
        #1;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [7:0] d;
        xfer(1'b1, idx, wd, d);
    endtask

    task automatic rdchk(input string name, input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] d;
        xfer(1'b0, idx, 8'h00, d);
        check(name, {24'h0, d}, {24'h0, exp});
    endtask

    task automatic pulse(input logic [9:0] v);
        @(posedge i_core_clk);
        ev <= v;
        @(posedge i_core_clk);
        ev <= 10'h000;
        #1;
    endtask

    task automatic go_sleep(input logic [6:0] exp);
        pulse(10'h001);
        check("mode", {25'h0, mode}, {25'h0, exp});
    endtask

    task automatic do_reset;
        @(posedge i_core_clk);
        i_srst <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        i_srst <= 1'b0;
        #1;
    endtask

    task automatic to_sub;
        wr(8'hf1, 8'h08);
        wr(8'hf0, 8'h88);
        go_sleep(7'h04);
    endtask

////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rdchk("cfg1", 8'hf0, 8'h07);
        rdchk("cfg2", 8'hf1, 8'he0);
        rdchk("en", 8'hf3, 8'h00);
        rdchk("req", 8'hf6, 8'h20);
        check("mode", {25'h0, mode}, 32'h1);
        rdchk("mode_stat", 8'hfa, 8'h01);
        check("hresp", {31'h0, resp}, 32'h0);
        wr(8'h10, 8'hff);
        rdchk("unmapped", 8'h10, 8'h00);
    endtask

    task automatic t_fields;
        for (int c = 0; c < 4; c++) begin
            wr(8'hf1, {3'h0, c[0], 2'h0, c[1:0]});
            check("sdiv", {30'h0, sdiv}, {30'h0, c[1:0]});
            check("ndiv", {28'h0, ndiv}, c[0] ? 32'h3 : 32'hf);
        end
        wr(8'hf0, 8'h08);
        check("subclk", {31'h0, subclk}, 32'h1);
        rdchk("cfg1", 8'hf0, 8'h0f);
        wr(8'hf0, 8'h00);
        check("subclk", {31'h0, subclk}, 32'h0);
    endtask

    task automatic t_direct;
        do_reset();
        wr(8'hf1, 8'h0c);
        go_sleep(7'h02);
        wr(8'hf1, 8'h08);
        go_sleep(7'h01);
        wr(8'hf0, 8'h88);
        @(posedge i_core_clk);
        pre3 <= 1'b0;
        go_sleep(7'h01);
        @(posedge i_core_clk);
        pre3 <= 1'b1;
        go_sleep(7'h04);
        wr(8'hf0, 8'h80);
        wr(8'hf1, 8'h0c);
        go_sleep(7'h02);
        wr(8'hf0, 8'h88);
        go_sleep(7'h04);
        wr(8'hf0, 8'h80);
        wr(8'hf1, 8'h08);
        go_sleep(7'h01);
    endtask

    task automatic t_sleep;
        do_reset();
        go_sleep(7'h08);
        do_reset();
        to_sub();
        wr(8'hf1, 8'h00);
        wr(8'hf0, 8'h08);
        go_sleep(7'h10);
        do_reset();
        to_sub();
        wr(8'hf1, 8'h00);
        go_sleep(7'h40);
        do_reset();
        wr(8'hf0, 8'h88);
        go_sleep(7'h40);
        do_reset();
        wr(8'hf0, 8'h80);
        go_sleep(7'h20);
    endtask

    // only the two shortest codes: the longer ones would dominate run time
    task automatic t_wait;
        int n;
        int exp;
        for (int k = 0; k < 2; k++) begin
            exp = k ? power_irq_pkg::WAIT_STATES_1 : power_irq_pkg::WAIT_STATES_0;
            do_reset();
            wr(8'hf0, k ? 8'h90 : 8'h80);
            go_sleep(7'h20);
            pulse(10'h010);
            n = 0;
            while (settle === 1'b1 && n < 70000) begin
                @(posedge i_core_clk);
                #1;
                n++;
            end
            if (n >= 70000) hang();
            check("wait", {31'h0, n >= exp - 2 && n <= exp + 2}, 32'h1);
            repeat (2) @(posedge i_core_clk);
            #1;
            check("mode", {25'h0, mode}, 32'h1);
            rdchk("stat", 8'hf8, 8'h03);
        end
    endtask

    task automatic t_flags;
        logic w;
        do_reset();
        pulse(10'h3ee);
        rdchk("req", 8'hf6, 8'hff);
        check("pend", {24'h0, pend}, 32'h0);
        wr(8'hf3, 8'hff);
        check("pend", {24'h0, pend}, 32'hdf);
        wr(8'hf6, 8'hff);
        rdchk("req", 8'hf6, 8'hff);
        wr(8'hf6, 8'h7f);
        rdchk("req", 8'hf6, 8'h7f);
        wr(8'hf6, 8'h00);
        rdchk("req", 8'hf6, 8'h20);
        wr(8'hf6, 8'hff);
        rdchk("req", 8'hf6, 8'h20);
        for (int i = 0; i < 5; i++) begin
            pulse(10'h020 << i);
            rdchk("req", 8'hf6, 8'h20 | (8'h01 << i));
            wr(8'hf6, 8'h00);
        end
        pulse(10'h004);
        rdchk("req", 8'hf6, 8'ha0);
        wr(8'hf6, 8'h00);
        pulse(10'h008);
        rdchk("req", 8'hf6, 8'h60);
        wr(8'hf6, 8'h00);
        wr(8'hf3, 8'h01);
        pulse(10'h060);
        check("pend", {24'h0, pend}, 32'h1);
        for (int e = 1; e >= 0; e--) begin
            wr(8'hf3, e ? 8'h20 : 8'h00);
            pulse(10'h002);
            w = wake_irq;
            @(posedge i_core_clk);
            #1;
            check("wake", {31'h0, w | wake_irq}, e);
        end
    endtask

    // status/mask/line: the line must follow an unmasked sticky bit only
    task automatic t_irq_line;
        do_reset();
        wr(8'hf9, 8'h01);
        wr(8'hf1, 8'h0c);
        go_sleep(7'h02);
        rdchk("stat", 8'hf8, 8'h01);
        check("irq", {31'h0, irq}, 32'h1);
        wr(8'hf8, 8'h01);
        check("irq", {31'h0, irq}, 32'h0);
        wr(8'hf9, 8'h04);
        wr(8'hf3, 8'h80);
        pulse(10'h004);
        @(posedge i_core_clk);
        #1;
        check("irq", {31'h0, irq}, 32'h1);
        wr(8'hf9, 8'h00);
        check("irq", {31'h0, irq}, 32'h0);
        wr(8'hf8, 8'hff);
        rdchk("stat", 8'hf8, 8'h00);
    endtask

////////////////////////////////////////////////////////////////////////////////
    initial begin
        i_srst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0000_0000;
        pre3 = 1'b1;
        ev = 10'h000;
        repeat (4) @(posedge i_core_clk);
        i_srst <= 1'b0;
        #1;
        t_reset();
        t_fields();
        t_direct();
        t_sleep();
        t_wait();
        t_flags();
        t_irq_line();
        wrap_up();
    end
endmodule
`default_nettype wire
